/* include/wdfw_consts.vh */
// Constants for the watchdog and fuse word block
`ifndef WDFW_CONSTS_VH
`define WDFW_CONSTS_VH
// Register indices as printed; byte address is four times the index
`define WDFW_IDX_TIMER_SETUP   16'h0081
`define WDFW_IDX_TIMER_MIRROR  16'h0181
`define WDFW_IDX_FUSE_WORD     16'h2007
`define WDFW_IDX_STATUS        16'h0003
// Special test and configuration space
`define WDFW_IDX_CFG_LO        16'h2000
`define WDFW_IDX_CFG_HI        16'h3fff
// Bus address width
`define WDFW_ADDR_W            16
// Timer setup register fields
`define WDFW_TS_OWNER_BIT      3
`define WDFW_TS_RATIO_HI       2
`define WDFW_TS_RATIO_LO       0
`define WDFW_TS_RESET          8'hff
// Fuse word fields
`define WDFW_FUSE_W            14
`define WDFW_FUSE_CP_HI        5
`define WDFW_FUSE_CP_LO        4
`define WDFW_FUSE_POWER_UP_TIMER_ENABLE_N_BIT    3
`define WDFW_FUSE_WATCHDOG_ENABLE_CFG_BIT     2
`define WDFW_FUSE_OSC_HI       1
`define WDFW_FUSE_OSC_LO       0
// Code protection selector codes
`define WDFW_CP_OFF            2'b11
`define WDFW_CP_HALF           2'b10
`define WDFW_CP_3QTR           2'b01
`define WDFW_CP_ALL            2'b00
// Oscillator selection codes
`define WDFW_OSC_RC            2'b11
`define WDFW_OSC_HS            2'b10
`define WDFW_OSC_XT            2'b01
`define WDFW_OSC_LP            2'b00
// Status register fields
`define WDFW_ST_TIMEOUT_N      0
`define WDFW_ST_WDOG_CAUSE     1
`define WDFW_ST_SLEEPING       2
`define WDFW_ST_POWER_UP_TIMER_BUSY      3
// Bus responses
`define WDFW_RESP_OKAY         2'b00
`define WDFW_RESP_SLVERR       2'b10
`define WDFW_RESP_DECERR       2'b11
// Timing: main clock, watchdog oscillator tick, periods
`define WDFW_CLK_PERIOD_NS     10
`define WDFW_RC_TICK_NS        1000
`define WDFW_WDT_PERIOD_MS     18
`define WDFW_POWER_UP_TIMER_PERIOD_MS    72
`define WDFW_WDT_TICKS         ((`WDFW_WDT_PERIOD_MS * 1000000) / `WDFW_RC_TICK_NS)
`define WDFW_POWER_UP_TIMER_CYCLES       ((`WDFW_POWER_UP_TIMER_PERIOD_MS * 1000000) / `WDFW_CLK_PERIOD_NS)
`endif

/* rtl/wdfw_top.v */
// Watchdog timer with its fuse word, timer setup register and AXI4-Lite slave
// Summary of operation
// - Fuse bits read 0 programmed, at 2007h
// - Config space readable only in programming mode
// - Protection code: 11 off, 10 half, 01 3/4, 00 all
// - Power-up timer enable fuse active low
// - Watchdog enable fuse: 1 on, 0 off
// - Oscillator code: 11 RC, 10 HS, 01 XT, 00 LP
// - Watchdog counts its own RC oscillator ticks
// - Awake time-out gives device reset, recorded
// - Sleeping time-out wakes device instead
// - Fuse-disabled watchdog cannot be software enabled
// - Base time-out period nominally 18 ms
// - Prescaler assignable via timer setup, up to 1:128
// - Kick or sleep clears watchdog, and prescaler only when assigned to it
// - Every time-out clears active-low time-out flag
// - Kick keeps prescaler assignment unchanged
// - Timer setup at 81h/181h, owner bit3, ratio 2:0
// - Power-up timer holds reset 72 ms after power-up
`timescale 1ns/1ps
`include "wdfw_consts.vh"

module wdfw_top #(
  parameter [23:0] WDT_TICKS   = `WDFW_WDT_TICKS,   // Base period in oscillator ticks
  parameter [23:0] POWER_UP_TIMER_CYCLES = `WDFW_POWER_UP_TIMER_CYCLES  // Power-up delay in main clocks
) (
  input  wire                     I_MCLK,         // Main clock
  input  wire                     I_RST,          // Power-on reset, async high
  input  wire                     I_RC_TICK,      // One pulse per watchdog oscillator period
  input  wire                     I_KICK_INSTR,   // Watchdog clear instruction executed
  input  wire                     I_SLEEP_INSTR,  // Sleep instruction executed
  input  wire                     I_PROG_MODE,    // Device in programming mode
  input  wire [`WDFW_FUSE_W-1:0]  I_FUSE_WORD,    // Raw fuse cells
  input  wire [`WDFW_ADDR_W-1:0]  I_AWADDR,       // AXI write address
  input  wire                     I_AWVALID,      // AXI write address valid
  output wire                     O_AWREADY,      // AXI write address ready
  input  wire [31:0]              I_WDATA,        // AXI write data
  input  wire [3:0]               I_WSTRB,        // AXI write strobes
  input  wire                     I_WVALID,       // AXI write data valid
  output wire                     O_WREADY,       // AXI write data ready
  output wire [1:0]               O_BRESP,        // AXI write response
  output wire                     O_BVALID,       // AXI write response valid
  input  wire                     I_BREADY,       // AXI write response ready
  input  wire [`WDFW_ADDR_W-1:0]  I_ARADDR,       // AXI read address
  input  wire                     I_ARVALID,      // AXI read address valid
  output wire                     O_ARREADY,      // AXI read address ready
  output wire [31:0]              O_RDATA,        // AXI read data
  output wire [1:0]               O_RRESP,        // AXI read response
  output wire                     O_RVALID,       // AXI read valid
  input  wire                     I_RREADY,       // AXI read ready
  output wire                     O_WDOG_RESET,   // One-cycle device reset request
  output wire                     O_WAKE,         // One-cycle wake-up request
  output wire                     O_CORE_HOLD,    // Device held in reset by power-up timer
  output wire [2:0]               O_PROT_QTRS,    // Protected quarters of program memory
  output wire [3:0]               O_OSC_MODE      // One-hot: rc, hs, xt, lp
);

  // Byte addresses of the registers
  localparam [`WDFW_ADDR_W-1:0] A_TS   = `WDFW_IDX_TIMER_SETUP << 2;
  localparam [`WDFW_ADDR_W-1:0] A_TSM  = `WDFW_IDX_TIMER_MIRROR << 2;
  localparam [`WDFW_ADDR_W-1:0] A_FUSE = `WDFW_IDX_FUSE_WORD << 2;
  localparam [`WDFW_ADDR_W-1:0] A_ST   = `WDFW_IDX_STATUS << 2;

  // Power-up states, one-hot
  localparam [2:0] PU_LOAD = 3'b001;  // Catch fuse word after reset release
  localparam [2:0] PU_WAIT = 3'b010;  // Power-up timer running
  localparam [2:0] PU_RUN  = 3'b100;  // Device running

  reg [2:0]               pu_q;          // Power-up state
  reg [23:0]              power_up_timer_cnt_q;    // Power-up timer count
  reg [`WDFW_FUSE_W-1:0]  fuse_q;        // Captured fuse word
  reg                     hold_q;        // Core reset hold
  reg [7:0]               ts_q;          // Timer setup register
  reg [7:0]               pre_cnt_q;     // Prescaler count
  reg [23:0]              wdt_cnt_q;     // Watchdog base count
  reg                     to_n_q;        // Active-low time-out flag
  reg                     cause_q;       // Last reset came from watchdog
  reg                     sleep_q;       // Device asleep
  reg                     wrst_q;        // Reset pulse
  reg                     wake_q;        // Wake pulse
  reg [2:0]               prot_q;        // Decoded protection
  reg [3:0]               osc_q;         // Decoded oscillator mode
  reg                     awr_q;         // Write address/data ready
  reg                     bvalid_q;      // Write response valid
  reg [1:0]               bresp_q;       // Write response code
  reg                     arr_q;         // Read address ready
  reg                     rvalid_q;      // Read data valid
  reg [1:0]               rresp_q;       // Read response code
  reg [31:0]              rdata_q;       // Read data

  // Fuse fields
  wire       wdt_on    = fuse_q[`WDFW_FUSE_WATCHDOG_ENABLE_CFG_BIT] & ~hold_q;
  wire       power_up_timer_en_n = I_FUSE_WORD[`WDFW_FUSE_POWER_UP_TIMER_ENABLE_N_BIT];
  wire [1:0] cp_sel    = fuse_q[`WDFW_FUSE_CP_HI:`WDFW_FUSE_CP_LO];
  wire [1:0] osc_sel   = fuse_q[`WDFW_FUSE_OSC_HI:`WDFW_FUSE_OSC_LO];

  // Prescaler owned by watchdog when owner bit is set
  wire       pre_own   = ts_q[`WDFW_TS_OWNER_BIT];
  wire [2:0] ratio     = ts_q[`WDFW_TS_RATIO_HI:`WDFW_TS_RATIO_LO];
  wire [7:0] pre_last  = (8'h01 << ratio) - 8'h01;
  wire       pre_tick  = I_RC_TICK & (~pre_own | (pre_cnt_q == pre_last));
  wire       restart   = I_KICK_INSTR | I_SLEEP_INSTR;
  wire       timeout   = wdt_on & pre_tick & ~restart &
                         (wdt_cnt_q == WDT_TICKS - 24'h000001);

  // Bus transfer strobes
  wire       wr_go = I_AWVALID & I_WVALID & ~awr_q & ~bvalid_q;
  wire       rd_go = I_ARVALID & ~arr_q & ~rvalid_q;
  wire       in_cfg_w = (I_AWADDR[`WDFW_ADDR_W-1:2] >= `WDFW_IDX_CFG_LO) &&
                        (I_AWADDR[`WDFW_ADDR_W-1:2] <= `WDFW_IDX_CFG_HI);
  wire       in_cfg_r = (I_ARADDR[`WDFW_ADDR_W-1:2] >= `WDFW_IDX_CFG_LO) &&
                        (I_ARADDR[`WDFW_ADDR_W-1:2] <= `WDFW_IDX_CFG_HI);
  wire       ts_hit_w = (I_AWADDR == A_TS) | (I_AWADDR == A_TSM);

  // Power-up sequence: catch fuses, then run power-up timer if enabled
  always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      pu_q       <= PU_LOAD;
      power_up_timer_cnt_q <= 24'h000000;
      fuse_q     <= {`WDFW_FUSE_W{1'b1}};
      hold_q     <= 1'b1;
    end else begin
      case (pu_q)
        PU_LOAD: begin
          fuse_q <= I_FUSE_WORD;
          if (!power_up_timer_en_n) begin
            pu_q <= PU_WAIT;
          end else begin
            pu_q   <= PU_RUN;
            hold_q <= 1'b0;
          end
        end
        PU_WAIT: begin
          // Only at power-up; watchdog resets never come back here
          if (power_up_timer_cnt_q == POWER_UP_TIMER_CYCLES - 24'h000001) begin
            pu_q   <= PU_RUN;
            hold_q <= 1'b0;
          end else begin
            power_up_timer_cnt_q <= power_up_timer_cnt_q + 24'h000001;
          end
        end
        PU_RUN: begin
          hold_q <= 1'b0;
        end
        default: begin
          pu_q <= PU_LOAD;
        end
      endcase
    end
  end

  // Fuse decodes for protection and oscillator mode
  always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      prot_q <= 3'h0;
      osc_q  <= 4'h0;
    end else begin
      case (cp_sel)
        `WDFW_CP_OFF:  prot_q <= 3'h0;
        `WDFW_CP_HALF: prot_q <= 3'h2;
        `WDFW_CP_3QTR: prot_q <= 3'h3;
        default:       prot_q <= 3'h4;
      endcase
      case (osc_sel)
        `WDFW_OSC_RC: osc_q <= 4'h8;
        `WDFW_OSC_HS: osc_q <= 4'h4;
        `WDFW_OSC_XT: osc_q <= 4'h2;
        default:      osc_q <= 4'h1;
      endcase
    end
  end

  // Prescaler and watchdog count on oscillator ticks
  always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      pre_cnt_q <= 8'h00;
      wdt_cnt_q <= 24'h000000;
    end else if (!wdt_on) begin
      // Disabled by fuse: nothing in software can start it
      pre_cnt_q <= 8'h00;
      wdt_cnt_q <= 24'h000000;
    end else if (restart) begin
      // Clears watchdog count, and prescaler count only when owned; assignment bit untouched
      wdt_cnt_q <= 24'h000000;
      if (pre_own) begin
        pre_cnt_q <= 8'h00;
      end
    end else if (I_RC_TICK) begin
      // Counts regardless of sleep state
      if (pre_own) begin
        pre_cnt_q <= pre_tick ? 8'h00 : pre_cnt_q + 8'h01;
      end
      if (pre_tick) begin
        wdt_cnt_q <= timeout ? 24'h000000 : wdt_cnt_q + 24'h000001;
      end
    end
  end

  // Time-out effects, sleep tracking and time-out flag
  always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      to_n_q  <= 1'b1;
      cause_q <= 1'b0;
      sleep_q <= 1'b0;
      wrst_q  <= 1'b0;
      wake_q  <= 1'b0;
    end else begin
      wrst_q <= timeout & ~sleep_q;
      wake_q <= timeout & sleep_q;
      if (timeout) begin
        to_n_q <= 1'b0;
        sleep_q <= 1'b0;
        if (!sleep_q) begin
          cause_q <= 1'b1;
        end
      end else if (restart) begin
        to_n_q <= 1'b1;
        if (I_SLEEP_INSTR) begin
          sleep_q <= 1'b1;
        end
      end
    end
  end

  // Write channel: takes address and data together, answers after handshake
  always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      awr_q    <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= `WDFW_RESP_OKAY;
      ts_q     <= `WDFW_TS_RESET;
    end else begin
      awr_q <= wr_go;
      if (wr_go) begin
        if (ts_hit_w) begin
          bresp_q <= `WDFW_RESP_OKAY;
          if (I_WSTRB[0]) begin
            ts_q <= I_WDATA[7:0];
          end
        end else if (in_cfg_w || I_AWADDR == A_ST) begin
          bresp_q <= `WDFW_RESP_SLVERR;
        end else begin
          bresp_q <= `WDFW_RESP_DECERR;
        end
      end
      // Response raised only once address and data handshake is done
      if (awr_q) begin
        bvalid_q <= 1'b1;
      end else if (bvalid_q && I_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel: decode at take, data valid after address handshake
  always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      arr_q    <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q  <= `WDFW_RESP_OKAY;
      rdata_q  <= 32'h00000000;
    end else begin
      arr_q <= rd_go;
      if (rd_go) begin
        rresp_q  <= `WDFW_RESP_OKAY;
        rdata_q  <= 32'h00000000;
        if (I_ARADDR == A_TS || I_ARADDR == A_TSM) begin
          rdata_q <= {24'h000000, ts_q};
        end else if (I_ARADDR == A_ST) begin
          rdata_q <= {28'h0000000, ~hold_q ^ 1'b1, sleep_q, cause_q, to_n_q};
        end else if (in_cfg_r && !I_PROG_MODE) begin
          rresp_q <= `WDFW_RESP_SLVERR;
        end else if (I_ARADDR == A_FUSE) begin
          rdata_q <= {18'h00000, fuse_q};
        end else if (!in_cfg_r) begin
          rresp_q <= `WDFW_RESP_DECERR;
        end
      end
      // Data offered only after the address handshake edge
      if (arr_q) begin
        rvalid_q <= 1'b1;
      end else if (rvalid_q && I_RREADY) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Outputs straight from flops
  assign O_AWREADY    = awr_q;
  assign O_WREADY     = awr_q;
  assign O_BVALID     = bvalid_q;
  assign O_BRESP      = bresp_q;
  assign O_ARREADY    = arr_q;
  assign O_RVALID     = rvalid_q;
  assign O_RRESP      = rresp_q;
  assign O_RDATA      = rdata_q;
  assign O_WDOG_RESET = wrst_q;
  assign O_WAKE       = wake_q;
  assign O_CORE_HOLD  = hold_q;
  assign O_PROT_QTRS  = prot_q;
  assign O_OSC_MODE   = osc_q;

endmodule // wdfw_top

/* tb/wdfw_chk.sv */
// Concurrent checks on the watchdog and fuse word block ports
`timescale 1ns/1ps
`include "wdfw_consts.vh"
module wdfw_chk #(
  parameter [23:0] WDT_TICKS   = 24'd8,  // Base period in ticks
  parameter [23:0] POWER_UP_TIMER_CYCLES = 24'd16  // Power-up delay in clocks
) (
  input wire                    I_MCLK,
  input wire                    I_RST,
  input wire                    I_PROG_MODE,
  input wire [`WDFW_FUSE_W-1:0] I_FUSE_WORD,
  input wire [`WDFW_ADDR_W-1:0] I_AWADDR,
  input wire                    I_AWVALID,
  input wire                    I_WVALID,
  input wire                    O_AWREADY,
  input wire [1:0]              O_BRESP,
  input wire                    O_BVALID,
  input wire                    I_BREADY,
  input wire [`WDFW_ADDR_W-1:0] I_ARADDR,
  input wire                    I_ARVALID,
  input wire                    O_ARREADY,
  input wire [31:0]             O_RDATA,
  input wire [1:0]              O_RRESP,
  input wire                    O_RVALID,
  input wire                    O_WDOG_RESET,
  input wire                    O_WAKE,
  input wire                    O_CORE_HOLD,
  input wire [2:0]              O_PROT_QTRS,
  input wire [3:0]              O_OSC_MODE
);
  localparam [15:0] FUSE_ADDR = `WDFW_IDX_FUSE_WORD << 2;  // Fuse word byte address
  reg  [24:0] hold_cnt_q;                                    // Edges spent in hold
  wire [24:0] hold_cnt_d = hold_cnt_q + {24'h0, O_CORE_HOLD}; // Next hold count
  wire        cfg_rd = I_ARVALID && !O_ARREADY && !O_RVALID && I_ARADDR == FUSE_ADDR;
  wire        cfg_wr = I_AWVALID && I_WVALID && !O_AWREADY && !O_BVALID && I_AWADDR == FUSE_ADDR;
  // Hold counter, restarts at every reset
  always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      hold_cnt_q <= 25'h0;
    end else begin
      hold_cnt_q <= hold_cnt_d;
    end
  end
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  a_osc_decode: assert property (
    !O_CORE_HOLD && !$past(O_CORE_HOLD) |-> O_OSC_MODE == (4'h1 << I_FUSE_WORD[1:0])) else $error("osc mode wrong");
  a_prot_decode: assert property (
    !O_CORE_HOLD && !$past(O_CORE_HOLD) |-> O_PROT_QTRS == (I_FUSE_WORD[5:4] == 2'b11 ? 3'd0 :
    I_FUSE_WORD[5:4] == 2'b10 ? 3'd2 : I_FUSE_WORD[5:4] == 2'b01 ? 3'd3 : 3'd4)) else $error("prot wrong");
  a_power_up_timer_length: assert property (
    !I_FUSE_WORD[3] |-> O_CORE_HOLD == (hold_cnt_q <= {1'b0, POWER_UP_TIMER_CYCLES})) else $error("hold length wrong");
  a_power_up_timer_skipped: assert property (
    I_FUSE_WORD[3] && hold_cnt_q != 25'h0 |-> !O_CORE_HOLD) else $error("hold while timer off");
  a_fuse_read_ok: assert property (
    cfg_rd && I_PROG_MODE |-> ##2 O_RVALID && O_RDATA == {18'h0, $past(I_FUSE_WORD, 2)}) else $error("fuse read wrong");
  a_fuse_read_guard: assert property (
    cfg_rd && !I_PROG_MODE |-> ##2 O_RVALID && O_RRESP == 2'b10 && O_RDATA == 32'h0) else $error("fuse read open");
  a_fuse_write_err: assert property (
    cfg_wr |-> ##2 O_BVALID && O_BRESP == 2'b10) else $error("fuse write accepted");
  a_b_after_hs: assert property (
    O_AWREADY |-> !O_BVALID) else $error("write response before handshake");
  a_r_after_hs: assert property (
    O_ARREADY |-> !O_RVALID) else $error("read data before handshake");
  a_dog_off_quiet: assert property (
    !I_FUSE_WORD[2] |-> !O_WDOG_RESET && !O_WAKE) else $error("disabled watchdog fired");
  a_pulse_single: assert property (
    O_WDOG_RESET || O_WAKE |=> !O_WDOG_RESET && !O_WAKE && !(O_WDOG_RESET && O_WAKE)) else $error("pulse too long");
  a_bresp_held: assert property (
    O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP)) else $error("bresp dropped");
  c_reset_pulse: cover property (O_WDOG_RESET);
  c_wake_pulse: cover property (O_WAKE);
  c_fuse_read: cover property (cfg_rd && I_PROG_MODE);
endmodule // wdfw_chk

/* tb/wdfw_top_tb.sv */
// Directed testbench for the watchdog and fuse word block
`timescale 1ns/1ps
`include "wdfw_consts.vh"
module wdfw_top_tb;
  localparam [23:0] WDT_TICKS   = 24'd8;                        // Shortened base period
  localparam [23:0] POWER_UP_TIMER_CYCLES = 24'd16;                       // Shortened power-up delay
  localparam [15:0] A_TS = `WDFW_IDX_TIMER_SETUP << 2;          // Timer setup
  localparam [15:0] A_TM = `WDFW_IDX_TIMER_MIRROR << 2;         // Its mirror
  localparam [15:0] A_ST = `WDFW_IDX_STATUS << 2;               // Status
  localparam [15:0] A_FW = `WDFW_IDX_FUSE_WORD << 2;            // Fuse word
  reg         i_mclk = 1'b0, i_rst = 1'b1, i_rc_tick = 1'b0, i_kick = 1'b0, i_sleep = 1'b0, i_prog = 1'b0;
  reg  [13:0] i_fuse = 14'h3fff;                                // Fuse cells
  reg  [15:0] i_awaddr = 16'h0, i_araddr = 16'h0;               // Bus addresses
  reg  [31:0] i_wdata = 32'h0;                                  // Write data
  reg  [3:0]  i_wstrb = 4'h0;                                   // Write strobes
  reg         i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  wire        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_wdog, o_wake, o_hold;
  wire [1:0]  o_bresp, o_rresp;                                 // Bus responses
  wire [31:0] o_rdata;                                          // Read data
  wire [2:0]  o_prot;                                           // Protected quarters
  wire [3:0]  o_osc;                                            // Oscillator mode
  integer     errors = 0, cmp_count = 0, n, i;                  // Counters and loop vars
  reg         hit, woke;                                        // Time-out seen, was wake
  reg  [31:0] rd;                                               // Last read data
  wdfw_top #(.WDT_TICKS(WDT_TICKS), .POWER_UP_TIMER_CYCLES(POWER_UP_TIMER_CYCLES)) u_wdfw_top (
    .I_MCLK(i_mclk), .I_RST(i_rst), .I_RC_TICK(i_rc_tick), .I_KICK_INSTR(i_kick), .I_SLEEP_INSTR(i_sleep),
    .I_PROG_MODE(i_prog), .I_FUSE_WORD(i_fuse), .I_AWADDR(i_awaddr), .I_AWVALID(i_awvalid),
    .O_AWREADY(o_awready), .I_WDATA(i_wdata), .I_WSTRB(i_wstrb), .I_WVALID(i_wvalid), .O_WREADY(o_wready),
    .O_BRESP(o_bresp), .O_BVALID(o_bvalid), .I_BREADY(i_bready), .I_ARADDR(i_araddr), .I_ARVALID(i_arvalid),
    .O_ARREADY(o_arready), .O_RDATA(o_rdata), .O_RRESP(o_rresp), .O_RVALID(o_rvalid), .I_RREADY(i_rready),
    .O_WDOG_RESET(o_wdog), .O_WAKE(o_wake), .O_CORE_HOLD(o_hold), .O_PROT_QTRS(o_prot), .O_OSC_MODE(o_osc));
  // 100 MHz main clock
  always #5 i_mclk = ~i_mclk;
  // Compare and count
  task check(input [31:0] seen, input [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bus write; address and data offered together, response checked
  task wr(input [15:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    reg done;
    begin
      done = 1'b0;
      @(posedge i_mclk);
      i_awaddr <= a; i_wdata <= d; i_wstrb <= s;
      i_awvalid <= 1'b1; i_wvalid <= 1'b1; i_bready <= 1'b1;
      while (!done) begin
        @(posedge i_mclk);
        if (o_awready) i_awvalid <= 1'b0;
        if (o_wready) i_wvalid <= 1'b0;
        if (o_bvalid) begin
          done = 1'b1; i_bready <= 1'b0;
          check(o_bresp, er);
        end
      end
    end
  endtask
  // Bus read; data kept in rd, checked where ed is not all ones
  task rdc(input [15:0] a, input [31:0] ed, input [1:0] er);
    reg done;
    begin
      done = 1'b0;
      @(posedge i_mclk);
      i_araddr <= a; i_arvalid <= 1'b1; i_rready <= 1'b1;
      while (!done) begin
        @(posedge i_mclk);
        if (o_arready) i_arvalid <= 1'b0;
        if (o_rvalid) begin
          done = 1'b1; i_rready <= 1'b0; rd = o_rdata;
          check(o_rresp, er);
          if (ed !== 32'hffffffff) check(o_rdata, ed);
        end
      end
    end
  endtask
  // Clear instruction or sleep instruction, one cycle
  task instr(input s);
    @(posedge i_mclk);
    if (s) i_sleep <= 1'b1; else i_kick <= 1'b1;
    @(posedge i_mclk);
    i_sleep <= 1'b0; i_kick <= 1'b0;
  endtask
  // Oscillator ticks until a time-out pulse or max ticks
  task ticks(input integer max);
    n = 0; hit = 1'b0; woke = 1'b0;
    while (!hit && n < max) begin
      @(posedge i_mclk); i_rc_tick <= 1'b1; n = n + 1;
      @(posedge i_mclk); i_rc_tick <= 1'b0;
      repeat (2) begin
        #1;
        if (o_wdog | o_wake) begin hit = 1'b1; woke = o_wake; end
        @(posedge i_mclk);
      end
    end
  endtask
  // Reset with a fuse image, then wait out the power-up hold
  task do_reset(input [13:0] f);
    @(posedge i_mclk);
    i_fuse <= f; i_rst <= 1'b1;
    repeat (4) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (60) if (o_hold) @(posedge i_mclk);
    repeat (2) @(posedge i_mclk);
  endtask
  // Final report and verdict
  task tally_and_finish;
    $display("compares %0d, errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Hang guard
  initial begin
    #600000;
    errors = errors + 1;
    tally_and_finish;
  end
  // Main sequence
  initial begin
    do_reset(14'h3fff);
    check(o_hold, 0);
    rdc(A_TS, 32'hff, 2'b00);
    wr(A_TS, 32'h0a, 4'hf, 2'b00);
    rdc(A_TM, 32'h0a, 2'b00);
    wr(A_TM, 32'h05, 4'h0, 2'b00);
    rdc(A_TS, 32'h0a, 2'b00);
    wr(A_FW, 32'h0, 4'hf, 2'b10);
    rdc(A_FW, 32'h0, 2'b10);
    i_prog <= 1'b1;
    rdc(A_FW, 32'h3fff, 2'b00);
    i_prog <= 1'b0;
    rdc(16'h0100, 32'h0, 2'b11);
    for (i = 0; i < 9; i = i + 1) begin
      wr(A_TS, (i < 8) ? 8 + i : 0, 4'hf, 2'b00);
      instr(1'b0);
      ticks(2000);
      check(n, (i < 8) ? WDT_TICKS << i : WDT_TICKS);
      check({hit, woke}, 2'b10);
    end
    rdc(A_ST, 32'hffffffff, 2'b00);
    check(rd[1:0], 2'b10);
    instr(1'b0);
    rdc(A_ST, 32'hffffffff, 2'b00);
    check(rd[0], 1'b1);
    ticks(5);
    instr(1'b0);
    ticks(100);
    check(n, WDT_TICKS);
    wr(A_TS, 32'h09, 4'hf, 2'b00);
    instr(1'b0);
    ticks(3);
    instr(1'b0);
    rdc(A_TS, 32'h09, 2'b00);
    ticks(100);
    check(n, WDT_TICKS * 2);
    ticks(5);
    instr(1'b1);
    ticks(100);
    check(n, WDT_TICKS * 2);
    check(woke, 1'b1);
    for (i = 0; i < 4; i = i + 1) begin
      do_reset({8'hff, i[1:0], i[0], i[1], i[1:0]});
      check(o_prot, (i == 3) ? 0 : (i == 2) ? 2 : (i == 1) ? 3 : 4);
      check(o_osc, 4'h1 << i);
      wr(A_TS, 32'h0, 4'hf, 2'b00);
      ticks(40);
      check(hit, i[1]);
    end
    tally_and_finish;
  end
endmodule // wdfw_top_tb
bind wdfw_top wdfw_chk #(.WDT_TICKS(WDT_TICKS), .POWER_UP_TIMER_CYCLES(POWER_UP_TIMER_CYCLES)) u_wdfw_chk (
  .I_MCLK(I_MCLK), .I_RST(I_RST), .I_PROG_MODE(I_PROG_MODE), .I_FUSE_WORD(I_FUSE_WORD),
  .I_AWADDR(I_AWADDR), .I_AWVALID(I_AWVALID), .I_WVALID(I_WVALID), .O_AWREADY(O_AWREADY),
  .O_BRESP(O_BRESP), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .I_ARADDR(I_ARADDR),
  .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP),
  .O_RVALID(O_RVALID), .O_WDOG_RESET(O_WDOG_RESET), .O_WAKE(O_WAKE), .O_CORE_HOLD(O_CORE_HOLD),
  .O_PROT_QTRS(O_PROT_QTRS), .O_OSC_MODE(O_OSC_MODE));
